// file: core/aad_decoder.sv
`timescale 1ns/1ps
`include "aad_defines.svh"
// What this block does
// RL1: Decode address bits 26..24 to one of eight areas, its select low.
// RL2: Address bit 27 clear gives 8-bit bus on low pins, set gives 16-bit.
// RL3: Byte on 16-bit space: even byte on pins 15..8, odd on 7..0.
// RL4: Split wide transfers into two or four consecutive bus accesses.
// RL5: Selects stay high for on-chip ROM, peripherals and RAM.
// RL6: Area 0 type and width come from the boot mode pins only.
// RL7: Bits 23 and 22 output only as multiplexed DRAM row; other external spaces mirror 4 Mbytes.
// RL8: In areas 1 to 4, bit 27 changes only the width, never the space reached.
// RL9: On-chip ROM repeats at its own size; upper bits ignored.
// RL10: Areas 0 and 2 external get 1 to 4 long waits from shared field.
// RL11: Area 1 is external memory, or DRAM with select high when enabled.
// RL12: DRAM with multiplexing puts bits 23..0 on pins 15..0 in two phases.
// RL13: Area 5 low half is peripherals, width from bit 8; high half 16-bit.
// RL14: Area 6 muxed I/O puts address then data on data pins, select low.
// RL15: Area 6 external width from bit 14 or 16-bit; own long wait field.
// RL16: Area 7 low half 8-bit external, high half 1-kbyte on-chip RAM.
// RL17: Areas 2, 3 and 4 are always external, width from bit 27.
// RL18: Masters make no forbidden access sizes to on-chip peripherals.
// RL19: All selects high outside a bus cycle; at most one ever low.
module aad_decoder #(
   parameter int ROM_ABITS    = 14,
   parameter int PERIPH_ABITS = 9,
   parameter int RAM_ABITS    = 10
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             arst_n,
   // AXI4-Lite register slave
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_awaddr,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   output logic [1:0]            s_axi_bresp,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   input  wire logic [31:0]      s_axi_araddr,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   // Master request and answer
   input  wire aad_pkg::aad_req_s req,
   output logic                  req_ready,
   output logic                  rsp_valid,
   output logic [31:0]           rsp_rdata,
   // Pins and on-chip targets
   input  wire logic [2:0]       boot_mode_pins,
   input  wire logic [15:0]      addr_data_pins_in,
   output aad_pkg::aad_ext_s     ext,
   output aad_pkg::aad_int_s     int_acc,
   input  wire logic [31:0]      int_rdata
);
   aad_pkg::aad_state_s r, n;

   // Register offsets as parameters so their low bits can be sliced
   localparam logic [31:0] CTRL_OFS = `AAD_CTRL_OFS;
   localparam logic [31:0] WAIT_OFS = `AAD_WAIT_OFS;
   localparam logic [31:0] STAT_OFS = `AAD_STAT_OFS;

   // Area, target kind, width and long waits of one address
   function automatic aad_pkg::aad_dec_s decode(input logic [31:0] a,
         input logic [2:0] mode, input logic [2:0] ctrl,
         input logic [3:0] lwait);
      aad_pkg::aad_dec_s d;
      d.area = a[`AAD_AREA_HI:`AAD_AREA_LO];                      // RL1
      d.kind = aad_pkg::AAD_K_EXT;
      d.wlog = a[`AAD_A27] ? `AAD_W16 : `AAD_W8;                  // RL2 RL8
      d.lw   = 3'h0;
      unique case (d.area)
         `AAD_AREA_BOOT: begin
            if (mode == `AAD_MODE_ROM) begin                      // RL6
               d.kind = aad_pkg::AAD_K_ROM;
               d.wlog = `AAD_W32;
            end else begin
               d.wlog = (mode == `AAD_MODE_EXT16) ? `AAD_W16 : `AAD_W8;
               d.lw   = {1'b0, lwait[`AAD_WAIT_A02]} + 3'h1;      // RL10
            end
         end
         `AAD_AREA_DRAM: begin
            if (ctrl[`AAD_CTRL_DRAM])
               d.kind = aad_pkg::AAD_K_DRAM;                      // RL11
         end
         `AAD_AREA_LW:
            d.lw = {1'b0, lwait[`AAD_WAIT_A02]} + 3'h1;           // RL10
         `AAD_AREA_EXT3, `AAD_AREA_EXT4: begin
            d.kind = aad_pkg::AAD_K_EXT;                          // RL17
         end
         `AAD_AREA_PERIPH: begin
            if (!a[`AAD_A27]) begin                               // RL13
               d.kind = aad_pkg::AAD_K_PERIPH;
               d.wlog = a[`AAD_A8] ? `AAD_W16 : `AAD_W8;
            end
         end
         `AAD_AREA_MUXIO: begin
            if (!a[`AAD_A27])
               d.wlog = a[`AAD_A14] ? `AAD_W16 : `AAD_W8;         // RL15
            if (!a[`AAD_A27] && ctrl[`AAD_CTRL_IOE])
               d.kind = aad_pkg::AAD_K_MUXIO;                     // RL14
            else
               d.lw = {1'b0, lwait[`AAD_WAIT_A6]} + 3'h1;         // RL15
         end
         `AAD_AREA_RAM: begin
            if (a[`AAD_A27]) begin                                // RL16
               d.kind = aad_pkg::AAD_K_RAM;
               d.wlog = `AAD_W32;
            end
         end
      endcase
      return d;
   endfunction : decode

   // Cycles of the data phase less one
   function automatic logic [4:0] span(input aad_pkg::aad_dec_s d,
         input logic wr);
      logic [4:0] c;
      c = {2'h0, d.lw};
      if (d.kind inside {aad_pkg::AAD_K_ROM, aad_pkg::AAD_K_PERIPH,
                         aad_pkg::AAD_K_RAM})
         c = 5'h00;
      else if (!wr)
         c = c + `AAD_RD_EXTRA;   // Pin data crosses two sync stages
      return c;
   endfunction : span

   function automatic logic two_phase(input aad_pkg::aad_dec_s d,
         input logic [2:0] ctrl);
      return d.kind == aad_pkg::AAD_K_MUXIO ||
             (d.kind == aad_pkg::AAD_K_DRAM && ctrl[`AAD_CTRL_MXE]);
   endfunction : two_phase

   // Next-state logic
   always_comb begin
      logic [31:0] slice;
      logic [31:0] wd;
      logic        internal;
      slice = 32'h00000000;
      wd = 32'h00000000;
      internal = 1'b0;
      n = r;
      n.mode_s1 = boot_mode_pins;
      n.mode_s2 = r.mode_s1;
      n.ad_s1   = addr_data_pins_in;
      n.ad_s2   = r.ad_s1;
      n.rsp_valid = 1'b0;
      // Mode strap caught once the sync stages hold real pin values
      if (!r.mode_done) begin
         if (r.mode_cnt == `AAD_SYNC_DEPTH) begin
            n.mode      = r.mode_s2;                              // RL6
            n.mode_done = 1'b1;
            n.req_ready = 1'b1;
         end else
            n.mode_cnt = r.mode_cnt + 2'h1;
      end
      // Register writes: address and data in either order
      if (r.awready && s_axi_awvalid) begin
         n.aw_got  = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (r.wready && s_axi_wvalid) begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready)
         n.bvalid = 1'b0;
      if (n.aw_got && n.w_got && !n.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = `AAD_RESP_OK;
         if (n.aw_addr[`AAD_OFS_MSB:0] == CTRL_OFS[`AAD_OFS_MSB:0]) begin
            if (n.wstrb[0])
               n.ctrl = n.wdata[2:0];
         end else if (n.aw_addr[`AAD_OFS_MSB:0] ==
                      WAIT_OFS[`AAD_OFS_MSB:0]) begin
            if (n.wstrb[0])
               n.lwait = n.wdata[3:0];
         end else if (n.aw_addr[`AAD_OFS_MSB:0] !=
                      STAT_OFS[`AAD_OFS_MSB:0])
            n.bresp = `AAD_RESP_ERR;
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready  = !n.w_got && !n.bvalid;
      // Register reads
      if (r.rvalid && s_axi_rready)
         n.rvalid = 1'b0;
      if (r.arready && s_axi_arvalid) begin
         n.rvalid = 1'b1;
         n.rresp  = `AAD_RESP_OK;
         unique case (s_axi_araddr[`AAD_OFS_MSB:0])
            CTRL_OFS[`AAD_OFS_MSB:0]: n.rdata = {29'h0, r.ctrl};
            WAIT_OFS[`AAD_OFS_MSB:0]: n.rdata = {28'h0, r.lwait};
            STAT_OFS[`AAD_OFS_MSB:0]:
               n.rdata = {24'h0, r.dec.area, r.st != aad_pkg::AAD_IDLE,
                          r.mode_done, r.mode};
            default: begin
               n.rdata = 32'h00000000;
               n.rresp = `AAD_RESP_ERR;
            end
         endcase
      end
      n.arready = !n.rvalid;
      // Access sequencer
      unique case (r.st)
         aad_pkg::AAD_IDLE: begin
            if (r.req_ready && req.valid) begin
               n.req_ready = 1'b0;
               n.req = req;
               n.req.wdata = req.wdata << (6'h20 - (6'h08 << req.size));
               n.dec = decode(req.addr, r.mode, r.ctrl, r.lwait);
               n.acc = 32'h00000000;
               if (req.size <= n.dec.wlog) begin
                  n.beats = 3'h1;
                  n.bpb   = req.size;
               end else begin
                  n.beats = 3'h1 << (req.size - n.dec.wlog);      // RL4
                  n.bpb   = n.dec.wlog;
               end
               n.cnt = span(n.dec, req.write);
               n.st  = two_phase(n.dec, r.ctrl) ? aad_pkg::AAD_PHASE1
                                                : aad_pkg::AAD_PHASE2;
            end
         end
         aad_pkg::AAD_PHASE1:
            n.st = aad_pkg::AAD_PHASE2;   // Address or row phase
         aad_pkg::AAD_PHASE2: begin
            if (r.cnt != 5'h00)
               n.cnt = r.cnt - 5'h01;
            else begin
               internal = r.intf.sel;
               unique case (r.bpb)
                  `AAD_W8: slice = internal ? {24'h0, int_rdata[7:0]} :
                     (r.dec.wlog == `AAD_W8 || r.req.addr[0]) ?
                     {24'h0, r.ad_s2[7:0]} : {24'h0, r.ad_s2[15:8]}; // RL3
                  `AAD_W16: slice = internal ? {16'h0, int_rdata[15:0]}
                                             : {16'h0, r.ad_s2};
                  default: slice = int_rdata;
               endcase
               n.acc = (r.acc << (6'h08 << r.bpb)) | slice;
               n.req.addr  = r.req.addr + (32'h1 << r.bpb);       // RL4
               n.req.wdata = r.req.wdata << (6'h08 << r.bpb);
               n.beats = r.beats - 3'h1;
               if (r.beats == 3'h1) begin
                  n.st        = aad_pkg::AAD_IDLE;
                  n.rsp_valid = 1'b1;
                  n.rsp_rdata = n.acc;
                  n.req_ready = 1'b1;
               end else begin
                  n.cnt = span(r.dec, r.req.write);
                  n.st  = two_phase(r.dec, r.ctrl) ? aad_pkg::AAD_PHASE1
                                                   : aad_pkg::AAD_PHASE2;
               end
            end
         end
      endcase
      // Pins and on-chip strobes from the next state
      n.ext  = '0;
      n.ext.area_select_n = 8'hFF;                                // RL19
      n.intf = '0;
      wd = n.req.wdata;
      if (n.st != aad_pkg::AAD_IDLE) begin
         if (n.dec.kind inside {aad_pkg::AAD_K_ROM, aad_pkg::AAD_K_PERIPH,
                                aad_pkg::AAD_K_RAM}) begin        // RL5
            n.intf.sel   = 1'b1;
            n.intf.kind  = n.dec.kind;
            n.intf.write = n.req.write;
            n.intf.size  = n.bpb;
            unique case (n.dec.kind)
               aad_pkg::AAD_K_ROM: n.intf.offset = n.req.addr[23:0] &
                  24'((32'h1 << ROM_ABITS) - 32'h1);              // RL9
               aad_pkg::AAD_K_PERIPH: n.intf.offset = n.req.addr[23:0] &
                  24'((32'h1 << PERIPH_ABITS) - 32'h1);           // RL13
               default: n.intf.offset = n.req.addr[23:0] &
                  24'((32'h1 << RAM_ABITS) - 32'h1);              // RL16
            endcase
            n.intf.wdata = (n.bpb == `AAD_W8)  ? {24'h0, wd[31:24]} :
                           (n.bpb == `AAD_W16) ? {16'h0, wd[31:16]} : wd;
         end else begin
            n.ext.strobe = 1'b1;
            n.ext.write  = n.req.write;
            n.ext.addr   = n.req.addr[`AAD_SHADOW_MSB:0];         // RL7
            if (n.dec.kind == aad_pkg::AAD_K_DRAM) begin
               n.ext.dram_strobe = 1'b1;                          // RL11
               if (n.ctrl[`AAD_CTRL_MXE])                         // RL12
                  n.ext.addr = (n.st == aad_pkg::AAD_PHASE1) ?
                     {6'h00, n.req.addr[`AAD_ROW_HI:`AAD_ROW_LO]} :
                     {6'h00, n.req.addr[15:0]};
            end else
               n.ext.area_select_n[n.dec.area] = 1'b0;            // RL1
            if (n.st == aad_pkg::AAD_PHASE1 &&
                n.dec.kind == aad_pkg::AAD_K_MUXIO) begin
               n.ext.addr_latch = 1'b1;                           // RL14
               n.ext.addr_data_pins_out = n.req.addr[15:0];
               n.ext.addr_data_pins_oe  = 16'hFFFF;
            end else if (n.st == aad_pkg::AAD_PHASE2 && n.req.write) begin
               if (n.dec.wlog == `AAD_W8) begin                   // RL2
                  n.ext.addr_data_pins_out[7:0] = wd[31:24];
                  n.ext.addr_data_pins_oe[7:0]  = 8'hFF;
               end else if (n.bpb == `AAD_W8 && !n.req.addr[0]) begin
                  n.ext.addr_data_pins_out[15:8] = wd[31:24];     // RL3
                  n.ext.addr_data_pins_oe[15:8]  = 8'hFF;
               end else if (n.bpb == `AAD_W8) begin
                  n.ext.addr_data_pins_out[7:0] = wd[31:24];      // RL3
                  n.ext.addr_data_pins_oe[7:0]  = 8'hFF;
               end else begin
                  n.ext.addr_data_pins_out = wd[31:16];           // RL2
                  n.ext.addr_data_pins_oe  = 16'hFFFF;
               end
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         r.ext.area_select_n <= 8'hFF;
      end else
         r <= n;
   end

   // Outputs straight from the state register
   assign s_axi_awready = r.awready;
   assign s_axi_wready  = r.wready;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata;
   assign s_axi_rresp   = r.rresp;
   assign req_ready     = r.req_ready;
   assign rsp_valid     = r.rsp_valid;
   assign rsp_rdata     = r.rsp_rdata;
   assign ext           = r.ext;
   assign int_acc       = r.intf;

   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   one_select_a: assert property ($onehot0(~ext.area_select_n)) // RL19
      else $error("more than one area select low");
   select_cycle_a: assert property (!ext.strobe |-> &ext.area_select_n)
      else $error("area select low outside a bus cycle"); // RL19
   onchip_quiet_a: assert property (int_acc.sel |-> &ext.area_select_n)
      else $error("area select low on on-chip access"); // RL5
   dram_quiet_a: assert property (ext.dram_strobe |-> &ext.area_select_n)
      else $error("area select low in DRAM space"); // RL11
   select_area_a: assert property (!(&ext.area_select_n) |->
      ext.area_select_n[r.dec.area] == 1'b0)
      else $error("wrong area select low"); // RL1
   answer_bound_a: assert property (req.valid && req_ready |->
      ##[1:80] rsp_valid)
      else $error("access never answered"); // RL4
   muxio_addr_a: assert property (ext.addr_latch |->
      ext.addr_data_pins_oe == 16'hFFFF ##1 !ext.addr_latch)
      else $error("muxed address phase wrong"); // RL14
   shadow_a: assert property (ext.strobe && !ext.dram_strobe |->
      ext.addr == r.req.addr[21:0])
      else $error("external address not mirrored"); // RL7
   byte_lane_a: assert property (ext.write && r.dec.wlog == `AAD_W16 &&
      r.bpb == `AAD_W8 && !r.req.addr[0] && r.st == aad_pkg::AAD_PHASE2 |->
      ext.addr_data_pins_oe == 16'hFF00)
      else $error("even byte not on upper lane"); // RL3
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   cov_long8_c: cover property (req.valid && req_ready &&
      req.size == 2'h2 && !req.addr[27]);
   cov_muxio_c: cover property (ext.addr_latch);
   cov_dram_c: cover property (ext.dram_strobe);
   cov_rom_c: cover property (int_acc.sel &&
      int_acc.kind == aad_pkg::AAD_K_ROM);
endmodule : aad_decoder

// file: core/aad_defines.svh
`ifndef AAD_DEFINES_SVH
`define AAD_DEFINES_SVH

// Register byte offsets
`define AAD_CTRL_OFS     32'h00000000
`define AAD_WAIT_OFS     32'h00000004
`define AAD_STAT_OFS     32'h00000008
`define AAD_OFS_MSB      7

// Address field positions
`define AAD_A27          27
`define AAD_AREA_HI      26
`define AAD_AREA_LO      24
`define AAD_A14          14
`define AAD_A8           8
`define AAD_SHADOW_MSB   21
`define AAD_ROW_HI       23
`define AAD_ROW_LO       8

// Area numbers
`define AAD_AREA_BOOT    3'h0
`define AAD_AREA_DRAM    3'h1
`define AAD_AREA_LW      3'h2
`define AAD_AREA_EXT3    3'h3
`define AAD_AREA_EXT4    3'h4
`define AAD_AREA_PERIPH  3'h5
`define AAD_AREA_MUXIO   3'h6
`define AAD_AREA_RAM     3'h7

// Boot mode pin patterns
`define AAD_MODE_EXT8    3'h0
`define AAD_MODE_EXT16   3'h1
`define AAD_MODE_ROM     3'h2

// Control and wait register bits
`define AAD_CTRL_DRAM    0
`define AAD_CTRL_MXE     1
`define AAD_CTRL_IOE     2
`define AAD_WAIT_A02     1:0
`define AAD_WAIT_A6      3:2

// Widths as log2 of bytes, sync depth, responses
`define AAD_W8           2'h0
`define AAD_W16          2'h1
`define AAD_W32          2'h2
`define AAD_SYNC_DEPTH   2'h2
`define AAD_RD_EXTRA     5'h02
`define AAD_RESP_OK      2'h0
`define AAD_RESP_ERR     2'h2

`endif

// file: core/aad_pkg.sv
package aad_pkg;
   typedef enum logic [2:0] {
      AAD_K_EXT, AAD_K_DRAM, AAD_K_MUXIO, AAD_K_ROM, AAD_K_PERIPH, AAD_K_RAM
   } aad_kind_e;
   typedef enum logic [1:0] {AAD_IDLE, AAD_PHASE1, AAD_PHASE2} aad_state_e;

   // Request from an internal bus master; size 0 byte, 1 word, 2 long
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } aad_req_s;

   // External pin group
   typedef struct packed {
      logic [7:0]  area_select_n;
      logic [21:0] addr;
      logic [15:0] addr_data_pins_out;
      logic [15:0] addr_data_pins_oe;
      logic        strobe;
      logic        write;
      logic        dram_strobe;
      logic        addr_latch;
   } aad_ext_s;

   // On-chip target access
   typedef struct packed {
      logic        sel;
      aad_kind_e   kind;
      logic [23:0] offset;
      logic [31:0] wdata;
      logic        write;
      logic [1:0]  size;
   } aad_int_s;

   typedef struct packed {
      aad_kind_e  kind;
      logic [2:0] area;
      logic [1:0] wlog;
      logic [2:0] lw;
   } aad_dec_s;

   typedef struct packed {
      logic [2:0]  mode_s1, mode_s2, mode;
      logic [1:0]  mode_cnt;
      logic        mode_done;
      logic [15:0] ad_s1, ad_s2;
      aad_state_e  st;
      aad_dec_s    dec;
      aad_req_s    req;
      logic [2:0]  beats;
      logic [1:0]  bpb;
      logic [4:0]  cnt;
      logic [31:0] acc;
      logic        req_ready, rsp_valid;
      logic [31:0] rsp_rdata;
      aad_ext_s    ext;
      aad_int_s    intf;
      logic [2:0]  ctrl;
      logic [3:0]  lwait;
      logic        awready, wready, bvalid, arready, rvalid;
      logic        aw_got, w_got;
      logic [1:0]  bresp, rresp;
      logic [31:0] aw_addr, wdata, rdata;
      logic [3:0]  wstrb;
   } aad_state_s;
endpackage : aad_pkg

// file: verif/aad_ext_mem.sv
`timescale 1ns/1ps
module aad_ext_mem (
   // Clock and bus pins
   input  wire logic              clk,
   input  wire aad_pkg::aad_ext_s ext,
   // Data returned to the block
   output logic [15:0]            pins
);
   logic [15:0] mem [0:255] = '{default: 16'h0};
   logic [15:0] last        = 16'h0;
   logic        rd_on;
   logic        wr_on;
   logic [7:0]  ix;
   // Device answers only while a select is low
   assign ix    = ext.addr[7:0];
   assign rd_on = ext.strobe && !ext.write && !(&ext.area_select_n);
   assign wr_on = ext.strobe && ext.write && !ext.addr_latch &&
                  !(&ext.area_select_n);
   // Merge driven lanes, remember last read value
   always @(posedge clk) begin
      if (wr_on)
         mem[ix] <= (mem[ix] & ~ext.addr_data_pins_oe) |
                    (ext.addr_data_pins_out & ext.addr_data_pins_oe);
      if (rd_on)
         last <= pins;
   end
   // Released bus shows inverse of last value
   assign pins = rd_on ? mem[ix] : ~last;
endmodule : aad_ext_mem

// file: verif/tb_aad_decoder.sv
`timescale 1ns/1ps
`include "aad_defines.svh"
module tb_aad_decoder;
   logic              clk = 0, arst_n = 0;
   logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic              s_axi_arvalid = 0, s_axi_rready = 0;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic              s_axi_arready, s_axi_rvalid, req_ready, rsp_valid;
   logic [31:0]       s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   logic [31:0]       s_axi_rdata, rsp_rdata, int_rdata, ad, rd, fa, fw;
   logic [3:0]        s_axi_wstrb = 4'hF;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   aad_pkg::aad_req_s req = '0;
   aad_pkg::aad_ext_s ext;
   aad_pkg::aad_int_s int_acc;
   logic [2:0]        boot_mode_pins = 3'h2;
   logic [15:0]       addr_data_pins_in, oe;
   logic [7:0]        cs;
   logic              alat, dstr;
   int                n_errors = 0, num_checks = 0, cyc = 0;
   int                lat, a, h, m, lw, nb;

   aad_decoder uut (.*);
   aad_ext_mem mem (.clk(clk), .ext(ext), .pins(addr_data_pins_in));

   // On-chip targets echo the masked offset
   assign int_rdata = {8'hC0, int_acc.offset};
   always #5 clk = ~clk;
   // Cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic rst(input logic [2:0] md);
      arst_n <= 0;
      boot_mode_pins <= md;
      repeat (2) @(posedge clk);
      arst_n <= 1;
      @(posedge clk);
      chk(ext.area_select_n, 8'hFF);
   endtask : rst

   // Register write, address and data offered together
   task automatic axw(input logic [31:0] ra, wd, input logic [1:0] er);
      logic aw, w;
      aw = 1;
      w = 1;
      s_axi_awaddr <= ra;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (aw || w) begin
         @(posedge clk);
         if (aw && s_axi_awready) begin
            aw = 0;
            s_axi_awvalid <= 0;
         end
         if (w && s_axi_wready) begin
            w = 0;
            s_axi_wvalid <= 0;
         end
      end
      // Response left waiting one cycle so it must hold
      @(posedge clk);
      s_axi_bready <= 1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(s_axi_bresp, er);
   endtask : axw

   task automatic axr(input logic [31:0] ra, ed, input logic [1:0] er);
      s_axi_araddr <= ra;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      @(posedge clk);
   endtask : axr

   // One master access; checks selects seen and cycles to answer
   task automatic acc(input logic w, input logic [1:0] sz,
                      input logic [31:0] xa, d, input logic [7:0] ecs,
                      input int elat);
      req <= {1'b1, w, sz, xa, d};
      do @(posedge clk); while (!req_ready);
      req.valid <= 0;
      lat = 0;
      cs = 0;
      oe = 0;
      alat = 0;
      dstr = 0;
      do begin
         @(posedge clk);
         lat++;
         cs |= ~ext.area_select_n;
         oe |= ext.addr_data_pins_oe;
         alat |= ext.addr_latch;
         dstr |= ext.dram_strobe;
         if (lat == 1) begin
            fa = {10'h0, ext.addr};
            fw = int_acc.wdata;
         end
         if ($countones(~ext.area_select_n) > 1)
            chk(32'h1, 32'h0);
      end while (!rsp_valid && lat < 100);
      rd = rsp_rdata;
      chk(cs, ecs);
      chk(lat, elat);
   endtask : acc

   initial begin
      // Registers: control reset value and unmapped offset
      rst(3'h2);
      axr(`AAD_CTRL_OFS, 32'h0, `AAD_RESP_OK);
      axr(32'h0000000C, 32'h0, `AAD_RESP_ERR);
      axw(32'h0000000C, 32'h7, `AAD_RESP_ERR);
      $display("test registers done");
      // Area 0 kind and width from strap, long wait of one state
      for (m = 0; m < 3; m++) begin
         rst(m[2:0]);
         acc(0, 2, 32'h08ABCD44, 0, m == 2 ? 8'h00 : 8'h01,
             m == 0 ? 17 : m == 1 ? 9 : 2);
         if (m == 2)
            chk(rd, 32'hC0000D44);
         axr(`AAD_STAT_OFS, {28'h0, 1'b1, m[2:0]}, `AAD_RESP_OK);
      end
      $display("test area 0 done");
      // Areas 2..4 both widths, shadow read back
      axw(`AAD_WAIT_OFS, 32'h3, `AAD_RESP_OK);
      for (a = 2; a < 5; a++) begin
         for (h = 0; h < 2; h++) begin
            ad = {4'h0, h[0], a[2:0], 16'h0, a[2:0], h[0], 4'h0};
            lw = (a == 2) ? 4 : 0;
            nb = h ? 2 : 4;
            acc(1, 2, ad, 32'h1234A5C0 + a, 8'h01 << a, nb * (1 + lw) + 1);
            chk(oe, h ? 32'hFFFF : 32'h00FF);
            acc(0, 2, ad ^ 32'h00C00000, 0, 8'h01 << a, nb * (3 + lw) + 1);
            chk(rd, 32'h1234A5C0 + a);
            chk(fa, ad & 32'h003FFFFF);
         end
      end
      $display("test areas 2 to 4 done");
      // Byte lanes on a 16-bit space
      for (h = 0; h < 2; h++) begin
         acc(1, 0, 32'h0B0000E0 | h, 32'h5A + h, 8'h08, 2);
         chk(oe, h ? 32'h00FF : 32'hFF00);
         acc(0, 0, 32'h0B0000E0 | h, 0, 8'h08, 4);
         chk(rd, 32'h5A + h);
      end
      $display("test byte lanes done");
      // Areas 5 and 7 halves; byte or word only to peripherals
      acc(0, 0, 32'h05ABCD12, 0, 8'h00, 2);
      acc(1, 1, 32'h05ABCD32, 32'h1, 8'h00, 2);
      chk(fw, 32'h1);
      acc(1, 2, 32'h0D000050, 32'h2, 8'h20, 3);
      acc(1, 2, 32'h07000060, 32'h3, 8'h80, 5);
      acc(0, 2, 32'h0F0007F4, 0, 8'h00, 2);
      chk(rd, 32'hC00003F4);
      $display("test areas 5 and 7 done");
      // Area 1 external, DRAM, DRAM with row/column phase
      acc(1, 1, 32'h01000070, 32'h4, 8'h02, 3);
      axw(`AAD_CTRL_OFS, 32'h1, `AAD_RESP_OK);
      acc(1, 0, 32'h01000074, 32'h5, 8'h00, 2);
      chk(dstr, 1);
      axw(`AAD_CTRL_OFS, 32'h3, `AAD_RESP_OK);
      acc(1, 0, 32'h01ABCD76, 32'h6, 8'h00, 3);
      chk(fa, 32'h0000ABCD);
      chk(dstr, 1);
      // Area 6 muxed I/O, then external widths
      axw(`AAD_CTRL_OFS, 32'h4, `AAD_RESP_OK);
      acc(1, 0, 32'h06000078, 32'h7, 8'h40, 3);
      chk(alat, 1);
      axw(`AAD_CTRL_OFS, 32'h0, `AAD_RESP_OK);
      acc(1, 1, 32'h060000A0, 32'h8, 8'h40, 5);
      acc(1, 1, 32'h060040A4, 32'h9, 8'h40, 3);
      acc(1, 1, 32'h0E0000A8, 32'hA, 8'h40, 3);
      $display("test areas 1 and 6 done");
      tally_and_finish();
   end
endmodule : tb_aad_decoder
